// ===== src/dcsr_pkg.sv
// constants and types shared by the chained serial readout block
package dcsr_pkg;
    localparam int unsigned CHANNELS = 4;
    localparam int unsigned RAW_BITS = 21;
    localparam int unsigned WORD_BITS = 20;
    localparam int unsigned NARROW_BITS = 16;
    localparam int unsigned FRAME_BITS = 80;
    localparam int unsigned NARROW_FRAME_BITS = 64;
    localparam int unsigned NARROW_TAP = FRAME_BITS - NARROW_FRAME_BITS;
    localparam logic [WORD_BITS-1:0] CODE_OFFSET = 20'h01000;
    localparam logic [WORD_BITS-1:0] CODE_MAX = 20'hfffff;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned FIRST_BIT_LEAD_NS = 1750;
    localparam int unsigned LEAD_CYC = (FIRST_BIT_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LEAD_W = 10;
    localparam logic [LEAD_W-1:0] LEAD_LAST = LEAD_W'(LEAD_CYC - 1);
    localparam int unsigned PIN_SCLK = 0;
    localparam int unsigned PIN_CHAIN = 1;
    localparam int unsigned PIN_MCLK = 2;
    localparam int unsigned PIN_WIDE = 3;
    localparam int unsigned PIN_COUNT = 4;
    localparam logic RESET_READY_N = 1'b1;

    typedef enum logic [2:0] {
        DCSR_IDLE = 3'b000,
        DCSR_LEAD = 3'b001,
        DCSR_WAIT_MCLK = 3'b010,
        DCSR_HOLD = 3'b011,
        DCSR_SHIFT = 3'b100
    } dcsr_state_e;
endpackage : dcsr_pkg

// ===== src/dcsr_result_buf.sv
// small result buffer between the converter core and the shift register
`timescale 1ns/10ps
`default_nettype none
module dcsr_result_buf #(
    parameter int unsigned WIDTH = 84,
    parameter int unsigned DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic in_ready_q, in_ready_d, out_valid_q, out_valid_d;
    logic push, pop;

    // ready and valid are registered, so both depend only on the stored count
    always_comb begin
        push = in_valid && in_ready_q;
        pop = out_valid_q && out_ready;
        wr_d = push ? ((wr_q == PTR_LAST) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d = pop ? ((rd_q == PTR_LAST) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
        in_ready_d = (cnt_d != CNT_FULL);
        out_valid_d = (cnt_d != '0);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready_q <= 1'b0;
            out_valid_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            in_ready_q <= in_ready_d;
            out_valid_q <= out_valid_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready = in_ready_q;
    assign out_valid = out_valid_q;
    assign out_data = mem_q[rd_q];
endmodule : dcsr_result_buf
`default_nettype wire

// ===== src/dcsr_readout.sv
// chained serial result readout port of a four-channel integrating converter
`timescale 1ns/10ps
`default_nettype none
module dcsr_readout #(
    parameter int unsigned BUF_DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic shift_clock,
    input wire logic chain_in,
    input wire logic master_clock,
    input wire logic wide_word_sel,
    input wire logic integrator_side_select_valid,
    input wire logic [dcsr_pkg::CHANNELS*dcsr_pkg::RAW_BITS-1:0] integrator_side_select_data,
    output logic integrator_side_select_ready,
    output logic serial_out,
    output logic result_ready_n
);
    localparam int unsigned BW = dcsr_pkg::CHANNELS * dcsr_pkg::RAW_BITS;
    localparam int unsigned FB = dcsr_pkg::FRAME_BITS;
    localparam int unsigned WB = dcsr_pkg::WORD_BITS;
    localparam int unsigned NB = dcsr_pkg::NARROW_BITS;
    localparam int unsigned RB = dcsr_pkg::RAW_BITS;

    // pin synchronisers: three stages, a change counts once stages two and three agree
    logic [dcsr_pkg::PIN_COUNT-1:0] pins, s1_q, s2_q, s3_q, f_q, f_d;
    assign pins = {wide_word_sel, master_clock, chain_in, shift_clock};

    genvar gi;
    generate
        for (gi = 0; gi < dcsr_pkg::PIN_COUNT; gi++) begin : g_filt
            assign f_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : f_q[gi];
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            f_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= f_d;
        end
    end

    logic shift_fall, mclk_fall, chain_bit;
    assign shift_fall = f_q[dcsr_pkg::PIN_SCLK] && !f_d[dcsr_pkg::PIN_SCLK];
    assign mclk_fall = f_q[dcsr_pkg::PIN_MCLK] && !f_d[dcsr_pkg::PIN_MCLK];
    assign chain_bit = f_d[dcsr_pkg::PIN_CHAIN];

    // results wait here while the host is still busy, stalling the core
    logic buf_valid, load;
    logic [BW-1:0] buf_data;

    dcsr_result_buf #(
        .WIDTH(BW),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(integrator_side_select_valid),
        .in_data(integrator_side_select_data),
        .in_ready(integrator_side_select_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(load)
    );

    // per-channel coding into offset binary, packed channel 0 first
    logic [WB-1:0] code [dcsr_pkg::CHANNELS];
    logic [FB-1:0] frame_wide, frame_narrow;

    generate
        for (gi = 0; gi < dcsr_pkg::CHANNELS; gi++) begin : g_code
            logic [RB:0] sum;
            assign sum = {buf_data[gi*RB+RB-1], buf_data[gi*RB +: RB]}
                + (RB+1)'(dcsr_pkg::CODE_OFFSET);
            assign code[gi] = sum[RB] ? '0 : (sum[WB] ? dcsr_pkg::CODE_MAX : sum[WB-1:0]);
            assign frame_wide[FB-1-gi*WB -: WB] = code[gi];
            assign frame_narrow[FB-1-gi*NB -: NB] = code[gi][WB-1 -: NB];
        end
    endgenerate
    assign frame_narrow[dcsr_pkg::NARROW_TAP-1:0] = '0;

    dcsr_pkg::dcsr_state_e state_q, state_d;
    logic [FB-1:0] sh_q, sh_d;
    logic wide_q, wide_d;
    logic [dcsr_pkg::LEAD_W-1:0] cnt_q, cnt_d;
    logic ready_n_q, ready_n_d;
    logic sout_q, sout_d;

    // a newer result may replace one under readout; the host must be done by then
    assign load = buf_valid && (state_q == dcsr_pkg::DCSR_IDLE || state_q == dcsr_pkg::DCSR_SHIFT);

    always_comb begin
        state_d = state_q;
        sh_d = sh_q;
        wide_d = wide_q;
        cnt_d = cnt_q;
        ready_n_d = ready_n_q;
        if (load) begin
            sh_d = f_q[dcsr_pkg::PIN_WIDE] ? frame_wide : frame_narrow;
            wide_d = f_q[dcsr_pkg::PIN_WIDE];
            cnt_d = '0;
            state_d = dcsr_pkg::DCSR_LEAD;
        end else if (shift_fall) begin
            sh_d = {sh_q[FB-2:0], chain_bit};
            if (!wide_q) begin
                sh_d[dcsr_pkg::NARROW_TAP] = chain_bit;
            end
        end
        case (state_q)
            dcsr_pkg::DCSR_IDLE: begin
            end
            dcsr_pkg::DCSR_LEAD: begin
                if (!load) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == dcsr_pkg::LEAD_LAST) begin
                        state_d = dcsr_pkg::DCSR_WAIT_MCLK;
                    end
                end
            end
            dcsr_pkg::DCSR_WAIT_MCLK: begin
                if (mclk_fall) begin
                    ready_n_d = 1'b0;
                    state_d = dcsr_pkg::DCSR_HOLD;
                end
            end
            dcsr_pkg::DCSR_HOLD: begin
                if (shift_fall) begin
                    ready_n_d = 1'b1;
                    state_d = dcsr_pkg::DCSR_SHIFT;
                end
            end
            dcsr_pkg::DCSR_SHIFT: begin
            end
            default: begin
                state_d = dcsr_pkg::DCSR_IDLE;
                ready_n_d = dcsr_pkg::RESET_READY_N;
            end
        endcase
        sout_d = sh_d[FB-1];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= dcsr_pkg::DCSR_IDLE;
            sh_q <= '0;
            wide_q <= 1'b1;
            cnt_q <= '0;
            ready_n_q <= dcsr_pkg::RESET_READY_N;
            sout_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sh_q <= sh_d;
            wide_q <= wide_d;
            cnt_q <= cnt_d;
            ready_n_q <= ready_n_d;
            sout_q <= sout_d;
        end
    end

    assign serial_out = sout_q;
    assign result_ready_n = ready_n_q;

    // helper for checks: cycles since the last load, saturating
    logic [dcsr_pkg::LEAD_W-1:0] since_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            since_q <= '0;
        end else if (load) begin
            since_q <= '0;
        end else if (since_q != '1) begin
            since_q <= since_q + 1'b1;
        end
    end

    ready_mclk_a: assert property (
        @(posedge clk) disable iff (rst) $fell(ready_n_q) |-> $past(mclk_fall))
        else $error("ready fell without a master clock fall");
    lead_time_a: assert property (
        @(posedge clk) disable iff (rst)
        $fell(ready_n_q) |-> (since_q >= dcsr_pkg::LEAD_W'(dcsr_pkg::LEAD_CYC)))
        else $error("ready fell before the first bit lead time");
    ready_release_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(ready_n_q) |-> $past(shift_fall) && $past(state_q) == dcsr_pkg::DCSR_HOLD)
        else $error("ready rose without a shift clock fall");
    next_bit_a: assert property (
        @(posedge clk) disable iff (rst)
        shift_fall && !load |=> serial_out == $past(sh_q[FB-2]))
        else $error("serial output did not advance on shift fall");
    chain_capture_a: assert property (
        @(posedge clk) disable iff (rst)
        shift_fall && !load |=> sh_q[0] == $past(chain_bit))
        else $error("chain input not captured on shift fall");
    narrow_tap_a: assert property (
        @(posedge clk) disable iff (rst)
        shift_fall && !load && !wide_q |=> sh_q[dcsr_pkg::NARROW_TAP] == $past(chain_bit))
        else $error("narrow frame does not take chain bit at the tap");
    hold_still_a: assert property (
        @(posedge clk) disable iff (rst) !shift_fall && !load |=> $stable(sh_q))
        else $error("shift register moved without a shift edge");
    zero_code_a: assert property (
        @(posedge clk) disable iff (rst)
        load && f_q[dcsr_pkg::PIN_WIDE] && buf_data[RB-1:0] == '0
        |=> sh_q[FB-1 -: WB] == dcsr_pkg::CODE_OFFSET)
        else $error("zero input not coded at the offset");
    load_ready_a: assert property (
        @(posedge clk) disable iff (rst)
        load |=> ready_n_q [*8])
        else $error("ready low right after a load");

    ready_cycle_c: cover property (@(posedge clk) disable iff (rst)
        $fell(ready_n_q) ##[1:1000] $rose(ready_n_q));
    narrow_load_c: cover property (@(posedge clk) disable iff (rst)
        load && !f_q[dcsr_pkg::PIN_WIDE]);
    buf_full_c: cover property (@(posedge clk) disable iff (rst) integrator_side_select_valid && !integrator_side_select_ready);
endmodule : dcsr_readout
`default_nettype wire

// ===== dv/dcsr_host_model.sv
// behavioural host that drives the shift clock and chain input and captures serial output
`timescale 1ns/10ps
`default_nettype none
module dcsr_host_model (
    input wire logic start,
    input wire logic [7:0] nbits,
    input wire logic [79:0] chain_word,
    input wire logic serial_out,
    input wire logic result_ready_n,
    output logic shift_clock,
    output logic chain_in,
    output logic [159:0] cap,
    output logic rdy_after1,
    output logic done,
    output logic timed_out
);
    int i;
    int w;
    initial begin
        shift_clock = 1'b0;
        chain_in = 1'b0;
        cap = '0;
        rdy_after1 = 1'b0;
        done = 1'b0;
        timed_out = 1'b0;
        forever begin
            @(posedge start);
            done = 1'b0;
            timed_out = 1'b0;
            rdy_after1 = 1'b0;
            cap = '0;
            // step off the clock edge so pin changes never race the sampling flops
            #1;
            for (w = 0; w < 4000 && result_ready_n !== 1'b0; w++) #5;
            if (result_ready_n !== 1'b0) timed_out = 1'b1;
            for (i = 0; i < nbits; i++) begin
                cap[159-i] = serial_out;
                shift_clock = 1'b1;
                // chain setup and hold around fall
                chain_in = (i < 80) ? chain_word[79-i] : ~chain_in;
                #62.5 shift_clock = 1'b0;
                #62.5;
                if (i == 0) rdy_after1 = result_ready_n;
            end
            // frame ends, clock idles, line inverted
            chain_in = ~chain_in;
            done = 1'b1;
        end
    end
endmodule : dcsr_host_model
`default_nettype wire

// ===== dv/dcsr_readout_tb.sv
// self-checking bench for the chained serial readout port
`timescale 1ns/10ps
`default_nettype none
module dcsr_readout_tb;
    logic clk, rst, master_clock, wide_word_sel, integrator_side_select_valid, integrator_side_select_ready;
    logic serial_out, result_ready_n, shift_clock, chain_in, start, rdy_after1;
    logic done, timed_out, so_last, rr_last;
    logic [83:0] integrator_side_select_data;
    logic [7:0] nbits;
    logic [79:0] chain_word;
    logic [159:0] cap;
    int miscompares = 0;
    int checks_done = 0;
    int mc_div = 0;
    int since_mfall = 0;
    int so_stable = 0;

    dcsr_readout DUT (.clk(clk), .rst(rst), .shift_clock(shift_clock), .chain_in(chain_in),
        .master_clock(master_clock), .wide_word_sel(wide_word_sel), .integrator_side_select_valid(integrator_side_select_valid),
        .integrator_side_select_data(integrator_side_select_data), .integrator_side_select_ready(integrator_side_select_ready), .serial_out(serial_out),
        .result_ready_n(result_ready_n));
    dcsr_host_model host (.start(start), .nbits(nbits), .chain_word(chain_word),
        .serial_out(serial_out), .result_ready_n(result_ready_n), .shift_clock(shift_clock),
        .chain_in(chain_in), .cap(cap), .rdy_after1(rdy_after1), .done(done),
        .timed_out(timed_out));

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    function automatic logic [19:0] code_of(input logic [20:0] raw);
        logic signed [22:0] s;
        s = $signed({{2{raw[20]}}, raw}) + $signed({3'h0, dcsr_pkg::CODE_OFFSET});
        if (s < 0) return 20'h00000;
        if (s > $signed({3'h0, dcsr_pkg::CODE_MAX})) return dcsr_pkg::CODE_MAX;
        return s[19:0];
    endfunction : code_of

    function automatic logic [79:0] frame_of(input logic [83:0] d, input logic wide);
        logic [79:0] f;
        logic [19:0] c;
        f = '0;
        for (int k = 0; k < 4; k++) begin
            c = code_of(d[21*k +: 21]);
            if (wide) f[79-20*k -: 20] = c;
            else f[79-16*k -: 16] = c[19:4];
        end
        return f;
    endfunction : frame_of

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // free master clock, 50 cycles a period; watches the ready fall for lead and alignment
    always @(posedge clk) begin
        mc_div <= (mc_div == 24) ? 0 : mc_div + 1;
        if (mc_div == 24) master_clock <= ~master_clock;
        since_mfall <= (mc_div == 24 && master_clock) ? 0 : since_mfall + 1;
        so_stable <= (serial_out !== so_last) ? 0 : so_stable + 1;
        so_last <= serial_out;
        rr_last <= result_ready_n;
        if (rr_last === 1'b1 && result_ready_n === 1'b0) begin
            chk(since_mfall <= 8, "ready fall not after master fall");
            chk(so_stable >= 349, "first bit not ahead of ready");
        end
    end

    task automatic send(input logic [83:0] d);
        int n;
        @(posedge clk);
        integrator_side_select_data <= d;
        integrator_side_select_valid <= 1'b1;
        for (n = 0; n < 2000; n++) begin
            @(negedge clk);
            if (integrator_side_select_ready === 1'b1) break;
        end
        if (n == 2000) begin
            chk(1'b0, "integrator_side_select_ready never high");
            report_and_stop();
        end
        @(posedge clk);
        integrator_side_select_valid <= 1'b0;
    endtask : send

    task automatic host_read(input logic [7:0] n);
        int c;
        @(posedge clk);
        nbits <= n;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (c = 0; c < 12000; c++) begin
            @(posedge clk);
            if (done === 1'b1) break;
        end
        if (c == 12000 || timed_out === 1'b1) begin
            chk(1'b0, "host read hung");
            report_and_stop();
        end
        chk(rdy_after1 === 1'b1, "ready not released by shift fall");
    endtask : host_read

    task automatic s_frame(input logic [83:0] d, input logic wide);
        logic [79:0] exp_f;
        exp_f = frame_of(d, wide);
        chain_word = 80'h5a3c_96e1_0ff0_c3a5_7e18;
        @(posedge clk);
        wide_word_sel <= wide;
        // the width pin must clear the synchroniser before the load latches it
        repeat (4) @(posedge clk);
        send(d);
        host_read(wide ? 8'h50 : 8'h80);
        if (wide) chk(cap[159:80] === exp_f, "wide frame");
        else chk(cap[159:96] === exp_f[79:16], "narrow frame");
        if (!wide) chk(cap[95:32] === chain_word[79:16], "narrow chain bits");
    endtask : s_frame

    task automatic s_chain;
        logic [83:0] d;
        d = {21'h0abcde, 21'h012345, 21'h1ffff0, 21'h000000};
        chain_word = 80'hc35a_0ff0_9669_a5c3_1e87;
        send(d);
        host_read(8'ha0);
        chk(cap[159:80] === frame_of(d, 1'b1), "own bits before chain");
        chk(cap[79:0] === chain_word, "chain bits passed through");
    endtask : s_chain

    task automatic s_buffer;
        logic [83:0] c;
        c = {21'h054321, 21'h000001, 21'h1fe000, 21'h0fffff};
        send({4{21'h000111}});
        send({4{21'h000222}});
        send(c);
        repeat (4) @(posedge clk);
        chk(integrator_side_select_ready === 1'b0, "full buffer still accepts");
        host_read(8'h01);
        host_read(8'h01);
        host_read(8'h50);
        chk(cap[159:80] === frame_of(c, 1'b1), "stalled word lost");
        chk(integrator_side_select_ready === 1'b1, "buffer not drained");
    endtask : s_buffer

    initial begin
        rst = 1'b1;
        master_clock = 1'b0;
        wide_word_sel = 1'b1;
        integrator_side_select_valid = 1'b0;
        integrator_side_select_data = '0;
        start = 1'b0;
        nbits = '0;
        chain_word = '0;
        so_last = 1'b0;
        rr_last = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        s_frame({21'h0ff800, 21'h1f0000, 21'h1fffff, 21'h000123}, 1'b1);
        s_frame({21'h0ff800, 21'h1f0000, 21'h1fffff, 21'h000123}, 1'b0);
        wide_word_sel <= 1'b1;
        repeat (4) @(posedge clk);
        s_chain();
        s_buffer();
        report_and_stop();
    end
endmodule : dcsr_readout_tb
`default_nettype wire
